// *** pkg/slsb_pkg.sv ***
package slsb_pkg;
  // instruction encodings
  localparam int OP_WIDTH = 14;
  localparam int ACC_WIDTH = 8;
  localparam logic [13:0] SLEEP_WORD = 14'h0063;
  localparam logic [13:0] LMA_MASK = 14'h3e00;
  localparam logic [13:0] LMA_MATCH = 14'h3c00;
  localparam int LIT_LSB = 0;
  localparam int LIT_MSB = 7;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
  localparam logic [2:0] ALU_FLAGS_RESET = 3'h0;
  localparam logic POWER_DOWN_RESET = 1'h1;
  localparam logic EXPIRY_RESET = 1'h1;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // register map, byte addresses
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_ACC = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_WAKE = 12'h00c;
  localparam logic [11:0] ADDR_WDOG = 12'h010;
  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_EXP = 4;
  localparam int ST_SLEEP = 5;

  typedef enum logic [1:0] {
    SLSB_RUN = 2'b00,
    SLSB_SLEEP = 2'b01
  } slsb_state_t;

  // flags written by the alu
  typedef struct packed {
    logic carry;
    logic halfBorrow;
    logic zero;
  } slsb_flags_t;

  // alu result
  typedef struct packed {
    logic [7:0] diff;
    slsb_flags_t flags;
  } slsb_alu_t;
endpackage : slsb_pkg

// *** design/slsb_subtract.sv ***
`timescale 1ns/1ns
module slsb_subtract (
  // operands
  input wire logic [7:0] literal,
  input wire logic [7:0] acc,
  // result
  output slsb_pkg::slsb_alu_t result
);
  logic [8:0] full;
  logic [4:0] low;

  // literal minus accumulator, two's complement
  always_comb begin
    full = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
    low = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    result.diff = full[7:0];
    result.flags.carry = full[8];
    result.flags.halfBorrow = low[4];
    result.flags.zero = (full[7:0] == 8'h00);
  end
endmodule : slsb_subtract

// *** design/slsb_core.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - the power-down instruction word clears the power-down flag.
// - it also sets the expiry flag and clears watchdog counter and prescaler.
// - afterwards the core sleeps, oscillator halted, executing nothing until wake-up.
// - literal subtract computes literal minus accumulator, two's complement.
// - bit x ignored, literal from low eight bits, result always to accumulator.
// - carry is one with no borrow, zero when literal below accumulator.
module slsb_core #(
  // sizes; only the documented widths are served
  parameter int DATA_WIDTH = slsb_pkg::ACC_WIDTH,
  parameter int OP_WIDTH = slsb_pkg::OP_WIDTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sleep indication
  output logic oscHalted
);
  // state and next values
  slsb_pkg::slsb_state_t state, next_state;
  logic [DATA_WIDTH-1:0] acc, next_acc;
  slsb_pkg::slsb_flags_t flags, next_flags;
  logic powerDownFlag, next_powerDownFlag;
  logic expiryFlag, next_expiryFlag;
  logic [7:0] watchdogCounter, next_watchdogCounter;
  logic [7:0] prescaler, next_prescaler;
  logic [31:0] next_prdata;
  slsb_pkg::slsb_alu_t alu;
  // decode strobes
  logic wrAccess, rdSetup, issue, isSleep, isSub, known;
  logic accWr, wakeReq, wdogWr;
  logic [OP_WIDTH-1:0] opcode;

  // refuse sizes that the fixed subtractor and decode cannot serve
  if (DATA_WIDTH != slsb_pkg::ACC_WIDTH) begin : g_bad_width
    $error("slsb_core: DATA_WIDTH must be 8");
  end
  if (OP_WIDTH != slsb_pkg::OP_WIDTH) begin : g_bad_op
    $error("slsb_core: OP_WIDTH must be 14");
  end

  // status word: alu flags, power flags and sleep indication
  function automatic logic [31:0] packStatus(input slsb_pkg::slsb_flags_t f, input logic downFlag,
                                             input logic expFlag, input logic asleep);
    logic [31:0] word;
    word = slsb_pkg::RDATA_RESET;
    word[slsb_pkg::ST_CARRY] = f.carry;
    word[slsb_pkg::ST_HALF] = f.halfBorrow;
    word[slsb_pkg::ST_ZERO] = f.zero;
    word[slsb_pkg::ST_POWER_DOWN] = downFlag;
    word[slsb_pkg::ST_EXP] = expFlag;
    word[slsb_pkg::ST_SLEEP] = asleep;
    return word;
  endfunction : packStatus

  // address map decode; anything off the map answers with an error
  function automatic logic regKnown(input logic [11:0] addr);
    case (addr)
      slsb_pkg::ADDR_INSTR, slsb_pkg::ADDR_ACC, slsb_pkg::ADDR_STATUS, slsb_pkg::ADDR_WAKE,
      slsb_pkg::ADDR_WDOG: regKnown = 1'b1;
      default: regKnown = 1'b0;
    endcase
  endfunction : regKnown

  // apb decode; zero wait states
  assign wrAccess = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite; // read data captured in setup
  assign pready = 1'b1;
  assign opcode = pwdata[OP_WIDTH-1:0];
  assign issue = wrAccess && (paddr == slsb_pkg::ADDR_INSTR) && (state == slsb_pkg::SLSB_RUN);
  assign isSleep = (opcode == slsb_pkg::SLEEP_WORD);
  assign isSub = ((opcode & slsb_pkg::LMA_MASK) == slsb_pkg::LMA_MATCH);
  assign oscHalted = (state == slsb_pkg::SLSB_SLEEP);
  assign accWr = wrAccess && (paddr == slsb_pkg::ADDR_ACC);
  assign wakeReq = wrAccess && (paddr == slsb_pkg::ADDR_WAKE) && pwdata[0];
  assign wdogWr = wrAccess && (paddr == slsb_pkg::ADDR_WDOG) && (state == slsb_pkg::SLSB_RUN);

  // unmapped addresses and issue while asleep answer with an error
  always_comb begin
    known = regKnown(paddr);
    pslverr = psel && penable && (!known ||
              (pwrite && paddr == slsb_pkg::ADDR_INSTR && state != slsb_pkg::SLSB_RUN));
  end

  slsb_subtract u_sub (
    .literal(opcode[slsb_pkg::LIT_MSB:slsb_pkg::LIT_LSB]),
    .acc(acc),
    .result(alu)
  );

  // sequencer: run until the power-down word, then sleep until woken
  always_comb begin
    next_state = state;
    case (state)
      slsb_pkg::SLSB_RUN: begin
        if (issue && isSleep) begin
          next_state = slsb_pkg::SLSB_SLEEP;
        end
      end
      // wake request stands in for wake-up logic outside this block
      slsb_pkg::SLSB_SLEEP: begin
        if (wakeReq) begin
          next_state = slsb_pkg::SLSB_RUN;
        end
      end
      default: begin
        next_state = slsb_pkg::SLSB_RUN; // unused code falls back to run
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= slsb_pkg::SLSB_RUN;
    end else begin
      state <= next_state;
    end
  end

  // accumulator and alu flags; software load and subtract never coincide
  always_comb begin
    next_acc = acc;
    next_flags = flags;
    if (issue && isSub) begin
      next_acc = alu.diff;
      next_flags = alu.flags;
    end else if (accWr) begin
      next_acc = pwdata[DATA_WIDTH-1:0];
    end
  end

  // accumulator and flag registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc <= slsb_pkg::ACC_RESET;
      flags <= slsb_pkg::ALU_FLAGS_RESET;
    end else begin
      acc <= next_acc;
      flags <= next_flags;
    end
  end

  // power flags: only the power-down word touches them here
  always_comb begin
    next_powerDownFlag = powerDownFlag;
    next_expiryFlag = expiryFlag;
    if (issue && isSleep) begin
      next_powerDownFlag = 1'b0;
      next_expiryFlag = 1'b1;
    end
  end

  // power flag registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      powerDownFlag <= slsb_pkg::POWER_DOWN_RESET;
      expiryFlag <= slsb_pkg::EXPIRY_RESET;
    end else begin
      powerDownFlag <= next_powerDownFlag;
      expiryFlag <= next_expiryFlag;
    end
  end

  // watchdog counter and prescaler; writes while asleep are dropped
  always_comb begin
    next_watchdogCounter = watchdogCounter;
    next_prescaler = prescaler;
    if (issue && isSleep) begin
      next_watchdogCounter = slsb_pkg::WDOG_CLEAR;
      next_prescaler = slsb_pkg::PRESCALE_CLEAR;
    end else if (wdogWr) begin
      next_watchdogCounter = pwdata[7:0];
      next_prescaler = pwdata[15:8];
    end
  end

  // watchdog registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      watchdogCounter <= slsb_pkg::WDOG_CLEAR;
      prescaler <= slsb_pkg::PRESCALE_CLEAR;
    end else begin
      watchdogCounter <= next_watchdogCounter;
      prescaler <= next_prescaler;
    end
  end

  // read data: loaded in the setup cycle and held, so it stands
  // through the access phase where the master takes it
  always_comb begin
    next_prdata = prdata;
    if (rdSetup) begin
      case (paddr)
        slsb_pkg::ADDR_ACC: next_prdata = {24'h000000, acc};
        slsb_pkg::ADDR_STATUS: next_prdata = packStatus(flags, powerDownFlag, expiryFlag, oscHalted);
        slsb_pkg::ADDR_WDOG: next_prdata = {16'h0000, prescaler, watchdogCounter};
        default: next_prdata = slsb_pkg::RDATA_RESET;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= slsb_pkg::RDATA_RESET;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule : slsb_core

// *** test/slsb_core_chk.sv ***
`timescale 1ns/1ns
module slsb_core_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic oscHalted
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // decoded accesses
  logic wr, rdAcc;
  assign wr = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  property p_sleep;
    wr && paddr == slsb_pkg::ADDR_INSTR && pwdata[13:0] == slsb_pkg::SLEEP_WORD && !oscHalted |=> oscHalted;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after sleep word");
  property p_stay;
    oscHalted && !(wr && paddr == slsb_pkg::ADDR_WAKE && pwdata[0]) |=> oscHalted;
  endproperty
  a_stay: assert property (p_stay) else $error("left sleep without wake");
  property p_refuse;
    wr && paddr == slsb_pkg::ADDR_INSTR && oscHalted |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("instruction taken while asleep");
  property p_flags;
    rdAcc && paddr == slsb_pkg::ADDR_STATUS && oscHalted |-> prdata[4:3] == 2'b10;
  endproperty
  a_flags: assert property (p_flags) else $error("status flags wrong after sleep");
  property p_wdog;
    rdAcc && paddr == slsb_pkg::ADDR_WDOG && oscHalted |-> prdata[15:0] == 16'h0000;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not cleared by sleep");
  property p_issue_ok;
    wr && paddr == slsb_pkg::ADDR_INSTR && !oscHalted |-> !pslverr;
  endproperty
  a_issue_ok: assert property (p_issue_ok) else $error("instruction refused while running");
  // main scenarios
  c_sleep: cover property (wr && paddr == slsb_pkg::ADDR_INSTR && pwdata[13:0] == slsb_pkg::SLEEP_WORD);
  c_wake: cover property (oscHalted ##1 !oscHalted);
  c_refuse: cover property (wr && pslverr);
endmodule : slsb_core_chk

bind slsb_core slsb_core_chk i_chk (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pslverr, .oscHalted);

// *** test/sleep_and_literal_subtract_test.sv ***
`timescale 1ns/1ns
module sleep_and_literal_subtract_test;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, oscHalted, err;
  logic [7:0] lit, a, d;
  int errors = 0, cmp_count = 0;
  // x bit, literal, accumulator
  localparam logic [16:0] VEC [6] = '{17'h00201, 17'h00202, 17'h00203, 17'h100ff, 17'h1ff0f, 17'h01001};
  slsb_core i_dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .oscHalted);
  // clock
  initial begin
    forever #10 clock = ~clock;
  end
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, read data kept in rd
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 50) begin
      errors++;
      print_verdict;
    end
  endtask : apb
  // test sequence
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1;
    apb(0, slsb_pkg::ADDR_STATUS, 0);
    check(rd, 32'h18);
    foreach (VEC[i]) begin
      lit = VEC[i][15:8];
      a = VEC[i][7:0];
      d = lit - a;
      apb(1, slsb_pkg::ADDR_ACC, {24'h0, a});
      apb(1, slsb_pkg::ADDR_INSTR, {18'h0, 5'h1e, VEC[i][16], lit});
      apb(0, slsb_pkg::ADDR_ACC, 0);
      check(rd, {24'h0, d});
      apb(0, slsb_pkg::ADDR_STATUS, 0);
      check(rd & 32'h7, {29'h0, d == 0, lit[3:0] >= a[3:0], lit >= a});
    end
    $display("subtract test done");
    apb(1, slsb_pkg::ADDR_WDOG, 32'h5a3c);
    apb(1, slsb_pkg::ADDR_INSTR, 32'h63);
    check({31'h0, err}, 0);
    @(negedge clock);
    check({31'h0, oscHalted}, 1);
    apb(0, slsb_pkg::ADDR_STATUS, 0);
    check(rd & 32'h38, 32'h30);
    apb(0, slsb_pkg::ADDR_WDOG, 0);
    check(rd & 32'hffff, 0);
    apb(1, slsb_pkg::ADDR_INSTR, 32'h3c09);
    check({31'h0, err}, 1);
    apb(0, slsb_pkg::ADDR_ACC, 0);
    check(rd, 32'h0f);
    apb(1, slsb_pkg::ADDR_WAKE, 1);
    apb(0, slsb_pkg::ADDR_STATUS, 0);
    check(rd & 32'h20, 0);
    $display("sleep test done");
    print_verdict;
  end
endmodule : sleep_and_literal_subtract_test
